//--- asx_datapath.sv
// Datapath holding the working register and flags, writing results back.
`timescale 1ns/1ps
`default_nettype none

module asx_datapath
(
	// Clock, reset and enable.
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             clkEn,
	// Instruction issue.
	input  wire logic             instValid,
	input  wire asx_pkg::asx_op_t op,
	input  wire logic             destSel,
	input  wire logic [6:0]       fileAddr,
	input  wire logic [7:0]       fileRdData,
	input  wire logic [7:0]       literal,
	// File register write-back.
	output logic                  fileWrEn_ff,
	output logic [6:0]            fileWrAddr_ff,
	output logic [7:0]            fileWrData_ff,
	// Architectural state.
	output logic [7:0]            workReg_ff,
	output logic                  carryFlag_ff,
	output logic                  digit_carry_flag_ff,
	output logic                  zeroFlag_ff
);

	logic [7:0] aluResult;
	logic       aluCarry;
	logic       aluDigitCarry;
	logic       toFile;
	logic [7:0] nxt_workReg;
	logic       nxt_fileWrEn;
	logic [6:0] nxt_fileWrAddr;
	logic [7:0] nxt_fileWrData;
	logic       nxt_carryFlag;
	logic       nxt_digit_carry_flag;
	logic       nxt_zeroFlag;

	asx_alu u_alu
	(
		.op         (op),
		.workVal    (workReg_ff),
		.fileVal    (fileRdData),
		.literal    (literal),
		.result     (aluResult),
		.carry      (aluCarry),
		.digitCarry (aluDigitCarry)
	);

	// ****************************************
	// Decoding helpers
	// ****************************************
	// The literal form has no destination bit and always lands in work.
	function automatic logic writesFile
	(
		input asx_pkg::asx_op_t opIn,
		input logic             destIn
	);
		return (destIn == asx_pkg::DEST_FILE) && (opIn != asx_pkg::OP_XOR_LITERAL_INTO_WORK);
	endfunction

	// Only the subtraction produces meaningful carry and digit carry.
	function automatic logic updatesCarry
	(
		input asx_pkg::asx_op_t opIn
	);
		return opIn == asx_pkg::OP_SUB_WORK_FROM_FILE;
	endfunction

	// Swap leaves zero alone; the other three all update it.
	function automatic logic updatesZero
	(
		input asx_pkg::asx_op_t opIn
	);
		return opIn != asx_pkg::OP_NIBBLE_SWAP_FILE;
	endfunction

	// Zero test on a full result byte.
	function automatic logic isZeroByte
	(
		input logic [7:0] value
	);
		return value == asx_pkg::ZERO_BYTE;
	endfunction

	assign toFile = writesFile(op, destSel);

	// ****************************************
	// Working register
	// ****************************************
	// Work keeps its value unless a result is routed to it.
	always_comb
	begin
		nxt_workReg = workReg_ff;
		if (instValid && !toFile)
			nxt_workReg = aluResult;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			workReg_ff <= asx_pkg::W_RESET;
		else if (clkEn)
			workReg_ff <= nxt_workReg;
	end

	// ****************************************
	// File write-back
	// ****************************************
	// A strobe held for one enabled cycle; the file memory lives outside this block.
	// Address and data hold between writes so a slow file can sample late.
	always_comb
	begin
		nxt_fileWrEn = instValid && toFile;
		nxt_fileWrAddr = fileWrAddr_ff;
		nxt_fileWrData = fileWrData_ff;
		if (instValid && toFile)
		begin
			nxt_fileWrAddr = fileAddr;
			nxt_fileWrData = aluResult;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			fileWrEn_ff <= 1'b0;
			fileWrAddr_ff <= 7'h00;
			fileWrData_ff <= 8'h00;
		end
		else if (clkEn)
		begin
			fileWrEn_ff <= nxt_fileWrEn;
			fileWrAddr_ff <= nxt_fileWrAddr;
			fileWrData_ff <= nxt_fileWrData;
		end
	end

	// ****************************************
	// Carry and digit carry
	// ****************************************
	// Carry means no borrow, so equal operands leave both flags set.
	always_comb
	begin
		nxt_carryFlag = carryFlag_ff;
		nxt_digit_carry_flag = digit_carry_flag_ff;
		if (instValid && updatesCarry(op))
		begin
			nxt_carryFlag = aluCarry;
			nxt_digit_carry_flag = aluDigitCarry;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			carryFlag_ff <= 1'b0;
			digit_carry_flag_ff <= 1'b0;
		end
		else if (clkEn)
		begin
			carryFlag_ff <= nxt_carryFlag;
			digit_carry_flag_ff <= nxt_digit_carry_flag;
		end
	end

	// ****************************************
	// Zero flag
	// ****************************************
	// The flag follows the routed result, whichever destination it goes to.
	always_comb
	begin
		nxt_zeroFlag = zeroFlag_ff;
		if (instValid && updatesZero(op))
			nxt_zeroFlag = isZeroByte(aluResult);
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			zeroFlag_ff <= 1'b0;
		else if (clkEn)
			zeroFlag_ff <= nxt_zeroFlag;
	end

	// ****************************************
	// Limitations
	// ****************************************
	// The file value is used in the same cycle it is presented.
	// A read of a file just written must be forwarded by the caller,
	// since this block holds no copy of the file memory.
	// A low clock enable freezes every register, the strobe included,
	// so a pending write stays visible until the next enabled edge.

endmodule
`default_nettype wire

//--- asx_pkg.sv
// Package with opcodes, widths and reset values for the sub/swap/xor datapath.
package asx_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int NIB_LO = 0;
	localparam int NIB_HI = 4;
	localparam int NIB_W = 4;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic DEST_WORK = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	typedef enum logic [1:0]
	{
		OP_SUB_WORK_FROM_FILE = 2'b00,
		OP_NIBBLE_SWAP_FILE = 2'b01,
		OP_XOR_WORK_WITH_FILE = 2'b10,
		OP_XOR_LITERAL_INTO_WORK = 2'b11
	} asx_op_t;

endpackage

//--- asx_alu.sv
// Combinational arithmetic unit for the four operations.
`timescale 1ns/1ps
`default_nettype none

module asx_alu
(
	// Operation and operands.
	input  wire asx_pkg::asx_op_t op,
	input  wire logic [7:0]       workVal,
	input  wire logic [7:0]       fileVal,
	input  wire logic [7:0]       literal,
	// Result and flags.
	output logic [7:0]            result,
	output logic                  carry,
	output logic                  digitCarry
);

	logic [8:0] diff;
	logic [4:0] nibDiff;

	// Two's complement: f + ~W + 1; carry set means no borrow.
	always_comb
	begin
		diff = {1'b0, fileVal} + {1'b0, ~workVal} + 9'h001;
		nibDiff = {1'b0, fileVal[3:0]} + {1'b0, ~workVal[3:0]} + 5'h01;
		carry = diff[8];
		digitCarry = nibDiff[4];
		case (op)
			asx_pkg::OP_SUB_WORK_FROM_FILE: result = diff[7:0];
			asx_pkg::OP_NIBBLE_SWAP_FILE:
				result = {fileVal[asx_pkg::NIB_LO +: asx_pkg::NIB_W],
					fileVal[asx_pkg::NIB_HI +: asx_pkg::NIB_W]};
			asx_pkg::OP_XOR_WORK_WITH_FILE: result = workVal ^ fileVal;
			asx_pkg::OP_XOR_LITERAL_INTO_WORK: result = workVal ^ literal;
			default: result = asx_pkg::ZERO_BYTE;
		endcase
	end

endmodule
`default_nettype wire

//--- asx_asserts.sv
// Port assertions for the datapath.
`timescale 1ns/1ps
`default_nettype none
module asx_asserts
(
	input wire logic clk_sys, nrst, clkEn, instValid, destSel, fileWrEn_ff,
	input wire logic carryFlag_ff, digit_carry_flag_ff, zeroFlag_ff,
	input wire asx_pkg::asx_op_t op,
	input wire logic [6:0] fileAddr, fileWrAddr_ff,
	input wire logic [7:0] fileRdData, literal, fileWrData_ff, workReg_ff
);
	wire logic g = clkEn & instValid;
	wire logic [7:0] f = fileRdData;
	wire logic [7:0] w = workReg_ff;
	wire logic [7:0] r = op[1] ? (op[0] ? literal : f) ^ w : op[0] ? {f[3:0], f[7:4]} : f - w;
	wire logic [1:0] cd = {f >= w, f[3:0] >= w[3:0]};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_sub_flags: assert property (g && op == 2'h0 |=> {carryFlag_ff, digit_carry_flag_ff} == $past(cd))
		else $error("sub");
	a_dest_work: assert property (g && !destSel |=> !fileWrEn_ff && w == $past(r)) else $error("work");
	a_dest_file: assert property (g && destSel && op != 2'h3 |=> fileWrEn_ff && $stable(w)
		&& fileWrData_ff == $past(r) && fileWrAddr_ff == $past(fileAddr)) else $error("file");
	a_swap_flags: assert property (g && op == 2'h1 |=> $stable(zeroFlag_ff) && $stable(carryFlag_ff)
		&& $stable(digit_carry_flag_ff)) else $error("swap");
	a_swap_file: assert property (g && op == 2'h1 && destSel |=> fileWrData_ff == $past(r)) else $error("sw");
	a_xor_flags: assert property (g && op == 2'h2 |=> $stable(digit_carry_flag_ff)
		&& $stable(carryFlag_ff)) else $error("xor");
	a_lit_work: assert property (g && op == 2'h3 |=> w == $past(r) && !fileWrEn_ff) else $error("lit");
	a_zero_flag: assert property (g && op != 2'h1 |=> zeroFlag_ff == ($past(r) == 8'h0)) else $error("z");
	cover property (g && destSel && op == 2'h0);
	cover property (g && op == 2'h3 && r == 8'h0);
	cover property (!clkEn ##1 g);
endmodule
bind asx_datapath asx_asserts chk_u (.*);
`default_nettype wire

//--- alu_sub_swap_xor_ops_tb.sv
// Random bench for the datapath.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; $display("MISMATCH %0t out", $time); end end
module alu_sub_swap_xor_ops_tb;
	logic clk_sys = 0, nrst = 0, clkEn = 0, instValid = 0, destSel = 0, eC = 0, eD = 0, eZ = 0, eE = 0;
	logic fileWrEn_ff, carryFlag_ff, digit_carry_flag_ff, zeroFlag_ff;
	logic [6:0] fileAddr = 7'h0, eA = 7'h0, fileWrAddr_ff;
	logic [7:0] fileRdData = 8'h0, literal = 8'h0, eW = 8'h0, eF = 8'h0, r, fileWrData_ff, workReg_ff;
	logic [31:0] s = 32'hc613;
	asx_pkg::asx_op_t op = asx_pkg::OP_SUB_WORK_FROM_FILE;
	int n_mismatch = 0, check_count = 0, cyc = 0;
	asx_datapath dut_u (.*);
	always #12.5 clk_sys = ~clk_sys;
	task automatic end_sim;
		$display("TB checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// Expected result from the operation definitions, not from the design.
	function automatic logic [7:0] expRes(input logic [1:0] o, input logic [7:0] w, f, k);
		case (o)
			2'h0: return f + ~w + 8'h01;
			2'h1: return {f[3:0], f[7:4]};
			2'h2: return w ^ f;
			default: return w ^ k;
		endcase
	endfunction
	always @(posedge clk_sys)
		if (++cyc > 900)
		begin
			n_mismatch++;
			end_sim;
		end
	initial
	begin
		repeat (2) @(posedge clk_sys);
		#1 nrst = 1;
		for (int i = 0; i < 800; i++)
		begin
			s = xs(s);
			{clkEn, instValid, destSel, fileAddr} = {s[3:0] != 4'h0, s[4] | s[5], s[15:8]};
			op = asx_pkg::asx_op_t'(s[7:6]);
			fileRdData = s[17:16] == 2'h0 ? eW : s[25:18];
			literal = s[17:16] == 2'h1 ? eW : s[31:24];
			// Corner cases: file value equal to work for every operation, clock enabled.
			if (i % 32 == 0)
			begin
				{clkEn, instValid, fileRdData} = {2'b11, eW};
				op = asx_pkg::asx_op_t'(i[6:5]);
			end
			eE = clkEn ? 1'b0 : eE;
			if (clkEn && instValid)
			begin
				r = expRes(op, eW, fileRdData, literal);
				{eC, eD} = op == 2'h0 ? {fileRdData >= eW, fileRdData[3:0] >= eW[3:0]} : {eC, eD};
				eZ = op == 2'h1 ? eZ : r == 8'h0;
				if (destSel && op != 2'h3)
					{eE, eA, eF} = {1'b1, fileAddr, r};
				else
					eW = r;
			end
			@(posedge clk_sys);
			#1;
			`CHK(workReg_ff, eW)
			`CHK({fileWrEn_ff, fileWrAddr_ff, fileWrData_ff}, {eE, eA, eF})
			`CHK({carryFlag_ff, digit_carry_flag_ff}, {eC, eD})
			`CHK(zeroFlag_ff, eZ)
		end
		$display("TB random test done");
		end_sim;
	end
endmodule
`default_nettype wire
